// >>> include/ssc_pkg.sv
package ssc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int REF_HZ        = 4_000_000;
    localparam int DIV_CYCLES    = CLK_HZ / REF_HZ;
    localparam int REF_DELAY_US  = 16490;
    localparam int MAXW_TIME_US  = 16830;
    localparam int STOP_TIME_MS  = 2000;
    localparam int BRAKE_B_RPM   = 2440;
    localparam int REF_TICKS     = REF_DELAY_US * (REF_HZ / 1_000_000);
    localparam int MAXW_TICKS    = MAXW_TIME_US * (REF_HZ / 1_000_000);
    localparam int STOP_TICKS    = STOP_TIME_MS * (REF_HZ / 1000);
    localparam int BRAKE_B_TICKS = (60 * REF_HZ + BRAKE_B_RPM - 1) / BRAKE_B_RPM;
    localparam int CNT_W         = 24;
    localparam int CODES_PER_REV = 12;
    localparam int CODES_PER_CYC = 6;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
    localparam logic [7:0]  OFS_PERIOD    = 8'h10;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int          CTRL_REG_EN   = 0;
    localparam int          ST_SUPPLY     = 0;
    localparam int          ST_STATE      = 1;
    localparam int          ST_FAULT      = 3;
    localparam int          ST_SPEED_OK   = 4;
    localparam int          ST_STOPPED    = 5;
    localparam int          ST_VALID      = 6;
    localparam int          IRQ_W         = 4;
    localparam int          EV_FAULT      = 0;
    localparam int          EV_SPEED_IN   = 1;
    localparam int          EV_SPEED_OUT  = 2;
    localparam int          EV_STOPPED    = 3;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SPIN   = 2'b01,
        ST_BRAKE1 = 2'b11,
        ST_BRAKE2 = 2'b10
    } ssc_state_e;
    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } ssc_coil_s;
endpackage : ssc_pkg

// >>> logic/ssc_commutator.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_commutator
    import ssc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [2:0] hall,
    output ssc_coil_s       pattern,
    output logic            bad_code,
    output logic            marker
);
    logic [2:0] hall_q_r;
    logic       half_r;
    logic       wrap;

    // ------------------------------------------------------------
    // position code to coil pair, counterclockwise torque
    // ------------------------------------------------------------
    always_comb begin
        bad_code = 1'b0;
        case (hall)
            3'b000:  pattern = '{hi: 3'b001, lo: 3'b010};
            3'b100:  pattern = '{hi: 3'b001, lo: 3'b100};
            3'b110:  pattern = '{hi: 3'b010, lo: 3'b100};
            3'b111:  pattern = '{hi: 3'b010, lo: 3'b001};
            3'b011:  pattern = '{hi: 3'b100, lo: 3'b001};
            3'b001:  pattern = '{hi: 3'b100, lo: 3'b010};
            default: begin
                pattern  = '{hi: 3'b000, lo: 3'b000};
                bad_code = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // one marker per two code cycles (one revolution)
    // ------------------------------------------------------------
    assign wrap   = (hall_q_r == 3'b001) && (hall == 3'b000);
    assign marker = ce && wrap && half_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hall_q_r <= 3'b000;
            half_r   <= 1'b0;
        end else if (ce) begin
            hall_q_r <= hall;
            if (wrap) begin
                half_r <= ~half_r;
            end
        end
    end
endmodule : ssc_commutator
`default_nettype wire

// >>> logic/ssc_rev_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_rev_timer
    import ssc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             tick,
    input  wire logic             marker,
    output logic [CNT_W-1:0]      running,
    output logic [CNT_W-1:0]      period,
    output logic                  valid,
    output logic                  upd
);
    logic pend_r;
    logic started_r;

    // ------------------------------------------------------------
    // revolution time in reference ticks, saturating
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r    <= 1'b0;
            started_r <= 1'b0;
            running   <= '1;
            period    <= '1;
            valid     <= 1'b0;
            upd       <= 1'b0;
        end else if (ce) begin
            upd <= 1'b0;
            if (marker) begin
                pend_r <= 1'b1;
            end
            if (tick && (pend_r || marker)) begin
                pend_r    <= 1'b0;
                running   <= CNT_W'(1);
                started_r <= 1'b1;
                if (started_r) begin
                    period <= running;
                    valid  <= 1'b1;
                    upd    <= 1'b1;
                end
            end else if (tick && running != '1) begin
                running <= running + 1'b1;
            end
        end
    end
endmodule : ssc_rev_timer
`default_nettype wire

// >>> logic/ssc_top.sv
// Overview of operation
// - motor powered only while spin request low
// - supply on needs request and door latched
// - twelve segments, two coils, counterclockwise torque
// - position from three hall sensor levels
// - hold speed between 3564 and 3636 rpm
// - full width above 16.83 ms, linear down
// - marker starts 16.49 ms reference delay
// - comparator time sets drive gate on-time
// - coils driven only while gate high
// - flag bad hall sensor as fault
// - speed ok only in window, no fault
// - halted when last revolution exceeds two seconds
// - emergency retract on dc power loss
// - release brakes stage one, stage two slow
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ssc_top
    import ssc_pkg::*;
#(
    parameter int REF_T    = REF_TICKS,
    parameter int MAXW_T   = MAXW_TICKS,
    parameter int STOP_T   = STOP_TICKS,
    parameter int BRAKEB_T = BRAKE_B_TICKS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              motor_run_n,
    input  wire logic              door_locked_n,
    input  wire logic              dc_power_ok,
    input  wire logic              hall_sensor_a,
    input  wire logic              hall_sensor_b,
    input  wire logic              hall_sensor_c,
    output logic                   supply_on,
    output ssc_coil_s              coil,
    output logic                   brake_a,
    output logic                   brake_b,
    output logic                   motor_fault,
    output logic                   speed_ok_n,
    output logic                   disk_stopped_n,
    output logic                   emerg_retract,
    output logic                   irq
);
    localparam logic [CNT_W-1:0] REF_C    = CNT_W'(REF_T);
    localparam logic [CNT_W-1:0] MAXW_C   = CNT_W'(MAXW_T);
    localparam logic [CNT_W-1:0] SPAN_C   = CNT_W'(MAXW_T - REF_T);
    localparam logic [CNT_W-1:0] STOP_C   = CNT_W'(STOP_T);
    localparam logic [CNT_W-1:0] BRAKEB_C = CNT_W'(BRAKEB_T);
    localparam logic [4:0]       DIV_LAST = 5'(DIV_CYCLES - 1);

    ssc_state_e       state_r, state_nxt;
    ssc_coil_s        pattern;
    logic [4:0]       div_r;
    logic             tick, bad_code, marker, valid, upd, gate_r, slow, stopped, in_window, wr, rd_ok;
    logic [CNT_W-1:0] running, period, duty_r, pwm_r;
    logic [31:0]      ctrl_r, rdata;
    logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, events;

    // ------------------------------------------------------------
    // 4 MHz reference tick
    // ------------------------------------------------------------
    assign tick = (div_r == DIV_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 5'h00;
        end else if (ce) begin
            div_r <= tick ? 5'h00 : div_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // position sensing and revolution timing
    // ------------------------------------------------------------
    ssc_commutator u_comm (
        .clk      (pclk),
        .rst_n    (presetn),
        .ce       (ce),
        .hall     ({hall_sensor_a, hall_sensor_b, hall_sensor_c}),
        .pattern  (pattern),
        .bad_code (bad_code),
        .marker   (marker)
    );

    ssc_rev_timer u_rev (
        .clk     (pclk),
        .rst_n   (presetn),
        .ce      (ce),
        .tick    (tick),
        .marker  (marker),
        .running (running),
        .period  (period),
        .valid   (valid),
        .upd     (upd)
    );

    assign slow      = (running >= BRAKEB_C) || (valid && period >= BRAKEB_C);
    assign stopped   = (running >= STOP_C) || (valid && period >= STOP_C);
    assign in_window = valid && (period >= REF_C) && (period <= MAXW_C);

    // ------------------------------------------------------------
    // width regulation, once per revolution
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_r <= SPAN_C;
        end else if (ce) begin
            if (!valid || stopped) begin
                duty_r <= SPAN_C;
            end else if (upd) begin
                if (period >= MAXW_C) begin
                    duty_r <= SPAN_C;
                end else if (period <= REF_C) begin
                    duty_r <= '0;
                end else begin
                    duty_r <= period - REF_C;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_r  <= '0;
            gate_r <= 1'b0;
        end else if (ce) begin
            if (tick) begin
                pwm_r <= (pwm_r >= SPAN_C - 1'b1) ? '0 : pwm_r + 1'b1;
            end
            gate_r <= (pwm_r < duty_r) || !ctrl_r[CTRL_REG_EN];
        end
    end

    // ------------------------------------------------------------
    // run and braking sequence
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:   state_nxt = !motor_run_n ? ST_SPIN : ST_IDLE;
            ST_SPIN:   state_nxt = motor_run_n ? ST_BRAKE1 : ST_SPIN;
            ST_BRAKE1, ST_BRAKE2: begin
                if (!motor_run_n) begin
                    state_nxt = ST_SPIN;
                end else if (stopped) begin
                    state_nxt = ST_IDLE;
                end else if (slow) begin
                    state_nxt = ST_BRAKE2;
                end
            end
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_IDLE;
            supply_on <= 1'b0;
            brake_a   <= 1'b0;
            brake_b   <= 1'b0;
            coil      <= '0;
        end else if (ce) begin
            state_r   <= state_nxt;
            supply_on <= !motor_run_n && !door_locked_n;
            brake_a   <= (state_nxt == ST_BRAKE1) || (state_nxt == ST_BRAKE2);
            brake_b   <= (state_nxt == ST_BRAKE2);
            if (gate_r && !motor_run_n && !door_locked_n) begin
                coil <= pattern;
            end else begin
                coil <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_fault    <= 1'b0;
            speed_ok_n     <= 1'b1;
            disk_stopped_n <= 1'b0;
            emerg_retract  <= 1'b0;
        end else if (ce) begin
            motor_fault    <= bad_code || (motor_fault && !motor_run_n);
            speed_ok_n     <= !(in_window && !bad_code && !motor_fault);
            disk_stopped_n <= !stopped;
            emerg_retract  <= !dc_power_ok;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign events[EV_FAULT]     = bad_code && !motor_fault;
    assign events[EV_SPEED_IN]  = speed_ok_n && in_window && !bad_code && !motor_fault;
    assign events[EV_SPEED_OUT] = !speed_ok_n && !(in_window && !bad_code && !motor_fault);
    assign events[EV_STOPPED]   = disk_stopped_n && stopped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq        <= 1'b0;
        end else if (ce) begin
            if (wr && paddr == OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | events;
            end else begin
                irq_stat_r <= irq_stat_r | events;
            end
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // apb slave, one wait state
    // ------------------------------------------------------------
    assign wr    = psel && penable && !pready && pwrite;
    assign rd_ok = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_IRQ_STAT)
                   || (paddr == OFS_IRQ_MASK) || (paddr == OFS_PERIOD);

    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            OFS_CTRL:     rdata = ctrl_r;
            OFS_STATUS:   begin
                rdata[ST_SUPPLY]            = supply_on;
                rdata[ST_STATE +: 2]        = state_r;
                rdata[ST_FAULT]             = motor_fault;
                rdata[ST_SPEED_OK]          = !speed_ok_n;
                rdata[ST_STOPPED]           = !disk_stopped_n;
                rdata[ST_VALID]             = valid;
            end
            OFS_IRQ_STAT: rdata[IRQ_W-1:0] = irq_stat_r;
            OFS_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask_r;
            OFS_PERIOD:   rdata[CNT_W-1:0] = period;
            default:      rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            ctrl_r     <= CTRL_RESET;
            irq_mask_r <= '0;
        end else if (ce) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !rd_ok;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rdata;
            end
            if (wr && paddr == OFS_CTRL) begin
                ctrl_r <= {31'h0000_0000, pwdata[CTRL_REG_EN]};
            end
            if (wr && paddr == OFS_IRQ_MASK) begin
                irq_mask_r <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb_chk @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_supply;
        ce |=> supply_on == (!$past(motor_run_n) && !$past(door_locked_n));
    endproperty
    a_supply: assert property (p_supply) else $error("supply switch mismatch");
    property p_run_off;
        (ce && motor_run_n) |=> (!supply_on && coil == '0);
    endproperty
    a_run_off: assert property (p_run_off) else $error("motor powered without request");
    property p_pair;
        $onehot0(coil.hi) && $onehot0(coil.lo) && ((coil.hi & coil.lo) == 3'b000)
            && ($onehot(coil.hi) == $onehot(coil.lo));
    endproperty
    a_pair: assert property (p_pair) else $error("bad coil pair");
    property p_gate;
        (coil.hi != 3'b000) |-> $past(gate_r);
    endproperty
    a_gate: assert property (p_gate) else $error("coils driven with gate low");
    property p_fault;
        (ce && hall_sensor_a == hall_sensor_c && hall_sensor_b != hall_sensor_a) |=> motor_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("bad sensor not flagged");
    property p_speed_ok;
        !speed_ok_n |-> (!motor_fault && $past(period) >= REF_C && $past(period) <= MAXW_C);
    endproperty
    a_speed_ok: assert property (p_speed_ok) else $error("speed ok outside window");
    property p_stop;
        (ce && running >= STOP_C) |=> !disk_stopped_n;
    endproperty
    a_stop: assert property (p_stop) else $error("halt not reported");
    property p_maxw;
        (ce && upd && period >= MAXW_C) |=> duty_r == SPAN_C;
    endproperty
    a_maxw: assert property (p_maxw) else $error("width not maximal when slow");
    property p_fast;
        (ce && upd && valid && !stopped && period <= REF_C) |=> duty_r == '0;
    endproperty
    a_fast: assert property (p_fast) else $error("width not zero when fast");
    property p_nomark;
        !valid |-> duty_r == SPAN_C;
    endproperty
    a_nomark: assert property (p_nomark) else $error("width reduced without marker");
    property p_brake;
        (brake_b |-> brake_a) and (brake_a |-> !supply_on || $past(motor_run_n) == 1'b0);
    endproperty
    a_brake: assert property (p_brake) else $error("brake stage order broken");
    property p_retract;
        (ce && !dc_power_ok) |=> emerg_retract;
    endproperty
    a_retract: assert property (p_retract) else $error("no emergency retract");
    c_cov_spin: cover property (!speed_ok_n);
    c_cov_brake: cover property (brake_b);
    c_cov_irq: cover property (irq);
endmodule : ssc_top
`default_nettype wire

// >>> tb/ssc_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_motor_model (
    input  wire logic       pclk,
    input  wire logic       spin,
    input  wire logic       bad,
    input  wire logic [7:0] step,
    output logic            hall_sensor_a,
    output logic            hall_sensor_b,
    output logic            hall_sensor_c
);
    // ------------------------------------------------------------
    // forward rotation, step cycles a segment, twelve a revolution
    // ------------------------------------------------------------
    logic [2:0] seq [6] = '{3'b000, 3'b100, 3'b110, 3'b111, 3'b011, 3'b001};
    int         cnt     = 0;
    int         idx     = 0;
    always @(posedge pclk) begin
        if (spin) begin
            cnt <= (cnt >= step - 1) ? 0 : cnt + 1;
            if (cnt >= step - 1) begin
                idx <= (idx + 1) % 6;
            end
        end
    end
    // stopped rotor keeps its levels; bad sensor gives an illegal code
    assign {hall_sensor_a, hall_sensor_b, hall_sensor_c} = bad ? 3'b010 : seq[idx];
endmodule : ssc_motor_model
`default_nettype wire

// >>> tb/spindle_speed_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spindle_speed_control_tb
    import ssc_pkg::*;
;
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata;
    logic              run_n = 1, door_n = 1, dc_ok = 1, spin = 0, bad = 0, ha, hb, hc;
    logic              pready, pslverr, supply_on, brake_a, brake_b, fault, spd_n, stop_n, retract, irq;
    ssc_coil_s         coil;
    logic [32:0]       exp_q[$];
    logic [3:0]        rnd;
    logic [7:0]        step = 8'd100;
    int                mismatches = 0, cmp_count = 0;

    ssc_top #(.REF_T(40), .MAXW_T(60), .STOP_T(400), .BRAKEB_T(120)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .motor_run_n(run_n), .door_locked_n(door_n), .dc_power_ok(dc_ok), .hall_sensor_a(ha),
        .hall_sensor_b(hb), .hall_sensor_c(hc), .supply_on(supply_on), .coil(coil), .brake_a(brake_a),
        .brake_b(brake_b), .motor_fault(fault), .speed_ok_n(spd_n), .disk_stopped_n(stop_n),
        .emerg_retract(retract), .irq(irq));
    ssc_motor_model i_motor (.pclk(pclk), .spin(spin), .bad(bad), .step(step), .hall_sensor_a(ha),
        .hall_sensor_b(hb), .hall_sensor_c(hc));

    always #5 pclk = ~pclk;

    task chk(input logic [32:0] e, input logic [32:0] a);
        cmp_count++;
        if (a !== e) begin
            mismatches++;
            $display("wrong value at %0t: expected %h got %h", $time, e, a);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        if (!w) exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
    endtask : apb
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task complete_run;
        if (exp_q.size() != 0) mismatches++;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // read monitor: oldest note against each completed read
    // ------------------------------------------------------------
    always @(negedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) chk(33'h1_0000_0000, 33'h0);
            else chk(exp_q.pop_front(), {pslverr, prdata});
        end
    end
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hbd08_84b6));
        wt(12);
        chk(33'h0, {supply_on, coil, brake_a, brake_b, stop_n, irq, retract});
        presetn <= 1;
        apb(0, OFS_CTRL, 0, {1'b0, CTRL_RESET});
        apb(0, OFS_PERIOD, 0, 33'h0_00FF_FFFF);
        apb(0, 8'h40, 0, 33'h1_0000_0000);
        rnd = 4'($urandom);
        apb(1, OFS_IRQ_MASK, {28'h0, rnd}, 0);
        apb(0, OFS_IRQ_MASK, 0, {29'h0, rnd});
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            run_n <= i[0]; door_n <= i[1];
            wt(2);
            chk(33'(i == 0), supply_on);
        end
        $display("test interlock done");
        apb(1, OFS_IRQ_MASK, 1, 0);
        bad <= 1;
        wt(4);
        chk(1, fault);
        chk(1, spd_n);
        chk(1, irq);
        run_n <= 1; bad <= 0;
        wt(4);
        apb(1, OFS_IRQ_STAT, 1, 0);
        apb(1, OFS_IRQ_MASK, 0, 0);
        wt(2);
        chk(0, {irq, fault});
        dc_ok <= 0;
        wt(2);
        chk(1, retract);
        dc_ok <= 1;
        $display("test fault done");
        run_n <= 0; door_n <= 0; spin <= 1;
        wt(2);
        chk(1, supply_on);
        wt(5000);
        chk(2'b01, {spd_n, stop_n});
        apb(0, OFS_PERIOD, 0, 33'd48);
        step <= 8'd60;
        wt(3000);
        chk(0, coil);
        chk(1, spd_n);
        run_n <= 1;
        wt(2);
        chk(3'b010, {supply_on, brake_a, brake_b});
        chk(0, coil);
        wt(1500);
        chk(0, brake_b);
        spin <= 0;
        wt(3200);
        chk(1, brake_b);
        wt(7200);
        chk(0, {stop_n, brake_a});
        $display("test spin done");
        complete_run();
    end
endmodule : spindle_speed_control_tb
`default_nettype wire
